//--- hw/kmd_regs.svh
// offsets, limits, response codes, reset values and timing counts of the keypad menu block
`ifndef KMD_REGS_SVH
`define KMD_REGS_SVH
`define KMD_CLK_HZ        40000000
`define KMD_MSG_TIME_MS   1000
`define KMD_MSG_CYC       ((`KMD_CLK_HZ / 1000) * `KMD_MSG_TIME_MS)
`define KMD_DEB_TIME_MS   10
`define KMD_DEB_CYC       ((`KMD_CLK_HZ / 1000) * `KMD_DEB_TIME_MS)
`define KMD_MONSEL_OFS    8'h00
`define KMD_STATUS_OFS    8'h04
`define KMD_MONSEL_RST    5'h00
`define KMD_MON_MAX       5'h10
`define KMD_FAULT_MIN     5'h01
`define KMD_FAULT_MAX     5'h16
`define KMD_GRP_MAX       3'h4
`define KMD_DIGITS        3'h5
`define KMD_RESP_OKAY     2'h0
`define KMD_RESP_DECERR   2'h3
`endif

//--- hw/kmd_pkg.sv
// types shared by the keypad menu block
package kmd_pkg;
  typedef enum logic [4:0] {
    G_0 = 5'h00, G_1 = 5'h01, G_2 = 5'h02, G_3 = 5'h03, G_4 = 5'h04,
    G_5 = 5'h05, G_6 = 5'h06, G_7 = 5'h07, G_8 = 5'h08, G_9 = 5'h09,
    G_BLANK = 5'h0A, G_MINUS = 5'h0B, G_A = 5'h0C, G_C = 5'h0D, G_D = 5'h0E,
    G_E = 5'h0F, G_L = 5'h10, G_N = 5'h11, G_O = 5'h12, G_P = 5'h13,
    G_R = 5'h14, G_S = 5'h15, G_U = 5'h16
  } kmd_glyph_t;
  typedef struct packed {
    logic group; logic shift; logic up; logic down; logic confirm;
  } kmd_keys_t;
  typedef struct packed {
    logic read_only; logic need_stop; logic volatile_only;
    logic restart; logic is_cmd; logic wide; logic signed_ok;
  } kmd_attr_t;
  typedef struct packed {
    logic [4:0][4:0] ch;
    logic [4:0]      dp;
    logic [4:0]      blink;
  } kmd_disp_t;
  typedef enum logic [2:0] {
    M_END = 3'h0, M_ERR_RO = 3'h1, M_ERR_PW = 3'h2, M_ERR_VAL = 3'h3,
    M_SRV_ON = 3'h4, M_NO_EE = 3'h5, M_RESTART = 3'h6
  } kmd_msg_t;
  typedef enum logic [5:0] {
    S_BOOT = 6'h01, S_MON = 6'h02, S_MONCODE = 6'h04,
    S_PARAM = 6'h08, S_SET = 6'h10, S_MSG = 6'h20
  } kmd_state_t;
endpackage : kmd_pkg

//--- hw/kmd_key_filter.sv
// debounce of one key with a single pulse per press
`timescale 1ns/1ps
`include "kmd_regs.svh"
module kmd_key_filter import kmd_pkg::*; #(
  parameter int CYC = `KMD_DEB_CYC
) (
  input  wire logic clk,       // system clock
  input  wire logic reset,     // async reset
  input  wire logic key_raw,   // raw key level, high while pressed
  output logic      key_press  // one-cycle pulse per press
);
  logic [31:0] cnt;
  logic        stable;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt       <= 32'h0;
      stable    <= 1'b0;
      key_press <= 1'b0;
    end else begin
      key_press <= 1'b0;
      if (key_raw == stable) begin
        cnt <= 32'h0;
      end else if (cnt >= 32'(CYC - 1)) begin
        cnt       <= 32'h0;
        stable    <= key_raw;
        key_press <= key_raw;
      end else begin
        cnt <= cnt + 32'h1;
      end
    end
  end
endmodule : kmd_key_filter

//--- hw/kmd_value_fmt.sv
// signed five-digit value to display glyphs and decimal points
`timescale 1ns/1ps
module kmd_value_fmt import kmd_pkg::*; (
  input  wire logic [19:0]     bcd,  // five bcd digits, digit 0 rightmost
  input  wire logic            neg,  // value is negative
  input  wire logic            wide, // value uses five digits
  output logic      [4:0][4:0] ch,   // glyphs, index 0 rightmost
  output logic      [4:0]      dp    // decimal points
);
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      ch[i] = bcd[i*4 +: 4] > 4'h9 ? G_BLANK : {1'b0, bcd[i*4 +: 4]};
    end
    dp = 5'h00;
    if (wide) begin
      dp = neg ? 5'h1F : 5'h00;
    end else begin
      ch[4] = neg ? G_MINUS : G_BLANK;
    end
  end
endmodule : kmd_value_fmt

//--- hw/kmd_menu.sv
// keypad menu state machine with display and register bus
//
// Overview of operation
// - confirm in parameter mode enters setting mode showing the current value
// - group key in setting mode returns to parameter mode, edit discarded
// - digit-left key moves the blinking cursor one digit left
// - up and down keys raise or lower the digit under the cursor
// - confirm stores the edited value, or executes a command parameter
// - each confirm in setting mode shows one outcome message for about one second
// - a good save shows the end code (volatile and restart parameters show their own message) then returns to parameter mode
// - read-only parameters are refused with the write-protected message
// - wrong or missing password refuses the change with its message
// - an invalid value is refused with the invalid value message
// - running servo refuses stop-only parameters with the running message
// - volatile parameters are accepted without a nonvolatile write
// - restart parameters are stored, old value kept until power-up
// - group key in parameter mode drops pending change, goes to monitor
// - a fault in monitor mode shows the alarm prefix and two-digit code 1 to 22
// - five-digit negatives light all decimal points; sign via digit-left
// - shorter negatives show a leading minus; sign via digit-left
// - power-up shows the monitor code one second, then monitor mode
// - up/down step monitor quantities; the select register picks directly
// - power-up quantity is the stored monitor-select value, or 0 if that is above 16
// - monitor select values 0 to 16 name the seventeen quantities
`timescale 1ns/1ps
`include "kmd_regs.svh"
module kmd_menu import kmd_pkg::*; #(
  parameter int MSG_CYC = `KMD_MSG_CYC,
  parameter int DEB_CYC = `KMD_DEB_CYC
) (
  input  wire logic        clk,           // 40 MHz clock
  input  wire logic        reset,         // async reset, active high
  input  wire kmd_keys_t   key_raw,       // raw key levels
  input  wire logic [4:0]  mon_sel_stored,// stored monitor select value
  input  wire logic [19:0] mon_bcd,       // selected monitor value, bcd
  input  wire logic        mon_neg,       // monitor value negative
  input  wire logic        mon_wide,      // monitor value uses five digits
  input  wire logic        fault_active,  // drive fault present
  input  wire logic [4:0]  fault_code,    // drive fault code
  input  wire logic [19:0] param_cur_bcd, // value of addressed parameter
  input  wire logic        param_cur_neg, // its sign
  input  wire logic [19:0] param_lim_bcd, // largest magnitude allowed
  input  wire kmd_attr_t   param_attr,    // attributes of addressed parameter
  input  wire logic        password_ok,   // password entered and correct
  input  wire logic        servo_running, // servo enabled and running
  output logic [2:0]       param_group,   // addressed parameter group
  output logic [5:0]       param_index,   // addressed parameter number
  output logic             param_wr,      // store pulse
  output logic             param_wr_nv,   // store also to nonvolatile memory
  output logic             param_deferred,// value takes effect at power-up
  output logic             param_exec,    // command execute pulse
  output logic [19:0]      param_wr_bcd,  // value stored
  output logic             param_wr_neg,  // sign stored
  output logic [4:0]       mon_sel,       // selected monitor quantity
  output kmd_disp_t        disp,          // display glyphs, points, blink
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready   // read data ready
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [9:0] two_dig(input logic [6:0] v);
    logic [6:0] t;
    t = v / 7'd10;
    return {1'b0, t[3:0], 1'b0, 4'(v - t * 7'd10)};
  endfunction : two_dig

  function automatic logic [3:0] bcd_step(input logic [3:0] d, input logic up);
    if (up) return (d >= 4'h9) ? 4'h0 : d + 4'h1;
    return (d == 4'h0) ? 4'h9 : d - 4'h1;
  endfunction : bcd_step

  function automatic logic [24:0] msg_ch(input kmd_msg_t m);
    case (m)
      M_END:     return {G_MINUS, G_E, G_N, G_D, G_MINUS};
      M_ERR_RO:  return {G_E, G_R, G_R, G_MINUS, G_R};
      M_ERR_PW:  return {G_E, G_R, G_R, G_MINUS, G_P};
      M_ERR_VAL: return {G_E, G_R, G_R, G_MINUS, G_C};
      M_SRV_ON:  return {G_S, G_R, G_U, G_O, G_N};
      M_NO_EE:   return {G_N, G_O, G_MINUS, G_E, G_E};
      default:   return {G_P, G_O, G_MINUS, G_O, G_N};
    endcase
  endfunction : msg_ch

  // ------------------------------------------------------------
  // key filters
  // ------------------------------------------------------------
  logic [4:0] press;
  kmd_keys_t  k;
  assign k = press;
  for (genvar i = 0; i < 5; i++) begin : g_key
    kmd_key_filter #(.CYC(DEB_CYC)) u_key (
      .clk       (clk),
      .reset     (reset),
      .key_raw   (key_raw[i]),
      .key_press (press[i])
    );
  end

  // ------------------------------------------------------------
  // outcome of a confirm
  // ------------------------------------------------------------
  kmd_state_t  state;
  logic [31:0] timer;
  logic [19:0] edit_bcd;
  logic        edit_neg;
  logic [2:0]  cursor;
  kmd_msg_t    msg;
  kmd_msg_t    next_msg;
  logic        refuse;
  logic [2:0]  top_digit;

  assign top_digit = param_attr.wide ? 3'h4 : 3'h3;

  // refusals are checked in this order; the first that applies is shown
  always_comb begin
    refuse   = 1'b1;
    next_msg = M_END;
    if (param_attr.read_only) begin
      next_msg = M_ERR_RO;
    end else if (!password_ok) begin
      next_msg = M_ERR_PW;
    end else if (servo_running && param_attr.need_stop) begin
      next_msg = M_SRV_ON;
    end else if (edit_bcd > param_lim_bcd || (edit_neg && !param_attr.signed_ok)) begin
      next_msg = M_ERR_VAL;
    end else begin
      refuse = 1'b0;
      if (param_attr.volatile_only) next_msg = M_NO_EE;
      else if (param_attr.restart) next_msg = M_RESTART;
    end
  end

  // ------------------------------------------------------------
  // menu state
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= S_BOOT;
      timer <= 32'h0;
      msg   <= M_END;
    end else begin
      if (timer != 32'h0) timer <= timer - 32'h1;
      case (state)
        S_BOOT: begin
          timer <= 32'(MSG_CYC - 1);
          state <= S_MONCODE;
        end
        S_MONCODE: begin
          if (timer == 32'h0) state <= S_MON;
        end
        S_MON: begin
          if (k.group) begin
            state <= S_PARAM;
          end else if (k.up || k.down) begin
            timer <= 32'(MSG_CYC - 1);
            state <= S_MONCODE;
          end
        end
        S_PARAM: begin
          if (k.group) state <= S_MON;
          else if (k.confirm) state <= S_SET;
        end
        S_SET: begin
          if (k.group) begin
            state <= S_PARAM;
          end else if (k.confirm) begin
            msg   <= next_msg;
            timer <= 32'(MSG_CYC - 1);
            state <= S_MSG;
          end
        end
        S_MSG: begin
          if (timer == 32'h0) state <= S_PARAM;
        end
        default: state <= S_BOOT;
      endcase
    end
  end

  // ------------------------------------------------------------
  // parameter address and edit buffer
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      param_group <= 3'h0;
      param_index <= 6'h00;
      edit_bcd    <= 20'h00000;
      edit_neg    <= 1'b0;
      cursor      <= 3'h0;
    end else if (state == S_PARAM) begin
      if (k.shift) param_group <= (param_group >= `KMD_GRP_MAX) ? 3'h0 : param_group + 3'h1;
      if (k.up) param_index <= param_index + 6'h01;
      if (k.down) param_index <= param_index - 6'h01;
      if (k.confirm) begin
        edit_bcd <= param_cur_bcd;
        edit_neg <= param_cur_neg;
        cursor   <= 3'h0;
      end
    end else if (state == S_SET) begin
      if (k.shift) begin
        if (cursor >= top_digit) begin
          cursor   <= 3'h0;
          edit_neg <= ~edit_neg;
        end else begin
          cursor <= cursor + 3'h1;
        end
      end else if (k.up || k.down) begin
        edit_bcd[cursor*4 +: 4] <= bcd_step(edit_bcd[cursor*4 +: 4], k.up);
      end
    end
  end

  // store and execute strobes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      param_wr       <= 1'b0;
      param_exec     <= 1'b0;
      param_wr_nv    <= 1'b0;
      param_deferred <= 1'b0;
      param_wr_bcd   <= 20'h00000;
      param_wr_neg   <= 1'b0;
    end else begin
      param_wr   <= 1'b0;
      param_exec <= 1'b0;
      if (state == S_SET && k.confirm && !k.group && !refuse) begin
        param_wr       <= !param_attr.is_cmd;
        param_exec     <= param_attr.is_cmd;
        param_wr_nv    <= !param_attr.volatile_only;
        param_deferred <= param_attr.restart;
        param_wr_bcd   <= edit_bcd;
        param_wr_neg   <= edit_neg;
      end
    end
  end

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic       w_be;
  logic       wr_fire;
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `KMD_RESP_OKAY;
      aw_addr       <= 8'h00;
      w_byte        <= 8'h00;
      w_be          <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_byte       <= s_axi_wdata[7:0];
        w_be         <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == `KMD_MONSEL_OFS || aw_addr == `KMD_STATUS_OFS) ?
                        `KMD_RESP_OKAY : `KMD_RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `KMD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `KMD_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      if (s_axi_araddr == `KMD_MONSEL_OFS) s_axi_rdata <= {27'h0, mon_sel};
      else if (s_axi_araddr == `KMD_STATUS_OFS) s_axi_rdata <= {14'h0, edit_neg, cursor, 1'b0, msg, 4'h0, state};
      else s_axi_rresp <= `KMD_RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // monitor select
  // ------------------------------------------------------------
  // the stored value is taken in the first clocked cycle after release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mon_sel <= `KMD_MONSEL_RST;
    end else if (state == S_BOOT) begin
      mon_sel <= (mon_sel_stored > `KMD_MON_MAX) ? `KMD_MONSEL_RST : mon_sel_stored;
    end else if (wr_fire && w_be && aw_addr == `KMD_MONSEL_OFS) begin
      if (w_byte[4:0] <= `KMD_MON_MAX && w_byte[7:5] == 3'h0) mon_sel <= w_byte[4:0];
    end else if (state == S_MON && k.up && !k.group) begin
      mon_sel <= (mon_sel >= `KMD_MON_MAX) ? 5'h00 : mon_sel + 5'h01;
    end else if (state == S_MON && k.down && !k.group) begin
      mon_sel <= (mon_sel == 5'h00) ? `KMD_MON_MAX : mon_sel - 5'h01;
    end
  end

  // ------------------------------------------------------------
  // display
  // ------------------------------------------------------------
  logic [4:0][4:0] fmt_ch;
  logic [4:0]      fmt_dp;
  logic            fault_ok;
  kmd_disp_t       next_disp;
  assign fault_ok = fault_active && fault_code >= `KMD_FAULT_MIN && fault_code <= `KMD_FAULT_MAX;

  kmd_value_fmt u_fmt (
    .bcd  (state == S_SET ? edit_bcd : mon_bcd),
    .neg  (state == S_SET ? edit_neg : mon_neg),
    .wide (state == S_SET ? param_attr.wide : mon_wide),
    .ch   (fmt_ch),
    .dp   (fmt_dp)
  );

  always_comb begin
    next_disp = '0;
    case (state)
      S_MON: begin
        if (fault_ok) next_disp.ch = {G_A, G_L, G_E, two_dig({2'b00, fault_code})};
        else begin
          next_disp.ch = fmt_ch;
          next_disp.dp = fmt_dp;
        end
      end
      S_PARAM: next_disp.ch = {G_P, 2'b00, param_group, G_MINUS, two_dig({1'b0, param_index})};
      S_SET: begin
        next_disp.ch    = fmt_ch;
        next_disp.dp    = fmt_dp;
        next_disp.blink = 5'(5'h01 << cursor);
      end
      S_MSG: next_disp.ch = msg_ch(msg);
      default: next_disp.ch = {G_MINUS, G_MINUS, G_BLANK, two_dig({2'b00, mon_sel})};
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) disp <= '0;
    else disp <= next_disp;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_confirm_enters_set: assert property (state == S_PARAM && k.confirm && !k.group |=>
    state == S_SET && edit_bcd == $past(param_cur_bcd)) else $error("confirm did not enter setting");
  chk_group_leaves_set: assert property (state == S_SET && k.group |=>
    state == S_PARAM && !param_wr) else $error("group key did not abandon edit");
  chk_cursor_left: assert property (state == S_SET && k.shift && !k.group && !k.confirm && cursor < top_digit |=>
    cursor == $past(cursor) + 3'h1 ##1 disp.blink[cursor])
    else $error("cursor did not move left");
  chk_digit_up: assert property (state == S_SET && k.up && !k.shift && !k.group && !k.confirm |=>
    edit_bcd != $past(edit_bcd)) else $error("digit unchanged by up key");
  chk_store_strobe: assert property (state == S_SET && k.confirm && !k.group && !refuse |=>
    (param_wr ^ param_exec) ##1 !param_wr && !param_exec) else $error("store strobe wrong");
  chk_msg_hold: assert property ($rose(state == S_MSG) |-> (state == S_MSG)[*8])
    else $error("message not held");
  chk_readonly_refused: assert property (state == S_SET && k.confirm && !k.group && param_attr.read_only |=>
    msg == M_ERR_RO && !param_wr && !param_exec) else $error("read-only write accepted");
  chk_group_to_monitor: assert property (state == S_PARAM && k.group |=> state == S_MON)
    else $error("group key did not return to monitor");
  chk_fault_shown: assert property (state == S_MON && fault_ok |=> disp.ch[4] == G_A)
    else $error("fault prefix missing");
  chk_monitor_step: assert property (state == S_MON && k.up && !k.group && !wr_fire && mon_sel < `KMD_MON_MAX |=>
    mon_sel == $past(mon_sel) + 5'h01 && state == S_MONCODE) else $error("monitor step wrong");

  cov_save_ok: cover property (state == S_SET && k.confirm ##1 msg == M_END ##[1:20] state == S_MSG);
  cov_sign_toggle: cover property (state == S_SET && k.shift && cursor == top_digit);
  cov_fault_display: cover property (state == S_MON && fault_ok);
endmodule : kmd_menu

//--- dv/kmd_store_model.sv
// parameter store model standing behind the keypad menu block
`timescale 1ns/1ps
module kmd_store_model (
  input  wire logic        clk,            // system clock
  input  wire logic        reset,          // async reset, active high
  input  wire logic        param_wr,       // store pulse
  input  wire logic        param_deferred, // value waits for power-up
  input  wire logic [19:0] param_wr_bcd,   // value to store
  output logic      [19:0] param_cur_bcd   // value in use
);
  // a deferred value is not taken: the old one stays in use until power-up
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      param_cur_bcd <= 20'h00012;
    end else if (param_wr && !param_deferred) begin
      param_cur_bcd <= param_wr_bcd;
    end
  end
endmodule : kmd_store_model

//--- dv/keypad_menu_display_control_tb.sv
// self-checking bench for the keypad menu block
`timescale 1ns/1ps
module keypad_menu_display_control_tb import kmd_pkg::*; ;
  logic clk = 0, reset = 1, fault_active = 0, password_ok = 1, servo_running = 0, mon_neg = 0, mon_wide = 0;
  kmd_keys_t key_raw = '0;
  kmd_attr_t param_attr = '0;
  kmd_disp_t disp;
  logic [4:0] mon_sel_stored = '0, fault_code = '0, mon_sel, x;
  logic [19:0] param_lim_bcd = 20'h09999, param_cur_bcd, param_wr_bcd;
  logic [2:0] param_group;
  logic [5:0] param_index;
  logic param_wr, param_wr_nv, param_deferred, param_exec, param_wr_neg;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, m_;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] bq[$];
  logic [31:0] mq[$];
  logic [21:0] pq[$];
  logic [2:0] msgs [7] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h5, 3'h0, 3'h6};
  logic [3:0] v = 4'h2;
  int miscompares = 0, n_tests = 0, k;

  kmd_menu #(.MSG_CYC(40), .DEB_CYC(2)) DUT (.clk, .reset, .key_raw, .mon_sel_stored, .mon_bcd(20'h00000),
    .mon_neg, .mon_wide, .fault_active, .fault_code, .param_cur_bcd, .param_cur_neg(1'b0),
    .param_lim_bcd, .param_attr, .password_ok, .servo_running, .param_group, .param_index, .param_wr,
    .param_wr_nv, .param_deferred, .param_exec, .param_wr_bcd, .param_wr_neg, .mon_sel, .disp,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  kmd_store_model MODEL (.clk, .reset, .param_wr, .param_deferred, .param_wr_bcd, .param_cur_bcd);

  initial forever #12.5 clk = ~clk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check(input string n, input logic [33:0] s, input logic [33:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task results;
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // one transfer, write or read; the expected answer goes on the queue
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    bq.push_back({r, d & m});
    mq.push_back(m);
    k = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) s_axi_bready <= 0;
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) s_axi_rready <= 0;
    end while ((s_axi_awvalid || s_axi_wvalid || s_axi_bready || s_axi_arvalid || s_axi_rready) && ++k < 60);
    if (k >= 60) begin
      miscompares++;
      results();
    end
  endtask : bus

  // held well past the debounce count, then released for ten cycles
  task press(input int b);
    key_raw[b] <= 1'b1;
    repeat (6) @(posedge clk);
    key_raw <= '0;
    repeat (10) @(posedge clk);
  endtask : press

  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge clk) begin
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
      m_ = mq.pop_front();
      if (s_axi_bvalid) check("bresp", {s_axi_bresp, 32'h0}, bq.pop_front());
      else check("rdata", {s_axi_rresp, s_axi_rdata & m_}, bq.pop_front());
    end
    if (param_wr) check("store", {param_wr_nv, param_deferred, param_wr_bcd},
      (pq.size() > 0) ? pq.pop_front() : 22'h3FFFFF);
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hC5597F19));
    mon_sel_stored = 5'($urandom % 20);
    // out-of-range stored selections fall back to quantity 0
    x = (mon_sel_stored > 5'h10) ? 5'h00 : mon_sel_stored;
    repeat (3) @(posedge clk);
    reset <= 0;
    repeat (60) @(posedge clk);
    bus(0, 8'h00, {27'h0, x}, 32'hFFFFFFFF, 2'h0);
    press(2);
    bus(0, 8'h00, {27'h0, (x == 5'h10) ? 5'h00 : 5'(x + 5'h01)}, 32'h1F, 2'h0);
    x = 5'($urandom % 17);
    bus(1, 8'h00, {27'h0, x}, 32'h0, 2'h0);
    bus(1, 8'h00, 32'h11, 32'h0, 2'h0);
    bus(0, 8'h00, {27'h0, x}, 32'hFFFFFFFF, 2'h0);
    bus(1, 8'h08, 32'h1, 32'h0, 2'h3);
    bus(0, 8'h0C, 32'h0, 32'hFFFFFFFF, 2'h3);
    repeat (40) @(posedge clk);
    press(4);
    bus(0, 8'h04, 32'h08, 32'h3F, 2'h0);
    press(0);
    bus(0, 8'h04, 32'h10, 32'h3F, 2'h0);
    check("digits", {disp.ch[1], disp.ch[0]}, {G_1, G_2});
    press(3);
    check("blink", disp.blink, 5'h02);
    bus(0, 8'h04, 32'h4010, 32'h1C03F, 2'h0);
    press(4);
    bus(0, 8'h04, 32'h08, 32'h3F, 2'h0);
    // refusal and save outcomes, restart kept last since the model holds the old value
    for (int i = 0; i < 7; i++) begin
      param_attr <= (i == 0) ? 7'h40 : (i == 2) ? 7'h20 : (i == 4) ? 7'h10 : (i == 6) ? 7'h08 : 7'h00;
      password_ok <= (i != 1);
      servo_running <= (i == 2);
      param_lim_bcd <= (i == 3) ? 20'h00000 : 20'h09999;
      if (i > 3) pq.push_back({i != 4, i == 6, 16'h0001, 4'(v + 4'h1)});
      press(0);
      press(2);
      press(0);
      bus(0, 8'h04, {19'h0, msgs[i], 10'h020}, 32'h1C3F, 2'h0);
      if (i == 4 || i == 5) v++;
      repeat (45) @(posedge clk);
      bus(0, 8'h04, 32'h08, 32'h3F, 2'h0);
    end
    press(4);
    bus(0, 8'h04, 32'h02, 32'h3F, 2'h0);
    mon_neg <= 1;
    mon_wide <= 1;
    repeat (3) @(posedge clk);
    check("wide sign", disp.dp, 5'h1F);
    mon_wide <= 0;
    repeat (3) @(posedge clk);
    check("narrow sign", {disp.ch[4], disp.dp}, {G_MINUS, 5'h00});
    mon_neg <= 0;
    repeat (50) @(posedge clk);
    fault_code <= 5'h0C;
    fault_active <= 1;
    repeat (5) @(posedge clk);
    check("alarm", disp.ch, {G_A, G_L, G_E, G_1, G_2});
    check("pending", pq.size(), 0);
    results();
  end
endmodule : keypad_menu_display_control_tb
